// *** rtl/spi_fault_device.sv ***
module spi_fault_device #(
   parameter int unsigned WD_LOWER_CYC = gd_pkg::WD_LOWER_CYC,
   parameter int unsigned WD_UPPER_CYC = gd_pkg::WD_UPPER_CYC
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_b,
   spi_link_if.device      link,
   input  wire logic       i_supply_undervoltage,
   input  wire logic       i_gate_supply_undervoltage,
   input  wire logic       i_drain_source_overcurrent,
   input  wire logic       i_overtemp_shutdown,
   input  wire logic       i_thermal_warning,
   input  wire logic [2:0] i_high_side_input,
   input  wire logic [2:0] i_phase_comparator,
   output logic            o_fault_n,
   output logic            o_gate_enable,
   output logic            o_charge_pump_enable,
   output logic            o_sense_enable,
   output logic      [3:0] o_oc_threshold
);
   typedef struct packed {
      logic [2:0]  cs_sy;
      logic [2:0]  sclk_sy;
      logic [1:0]  sdi_sy;
      logic [10:0] pin_s1;
      logic [10:0] pin_s2;
      logic [5:0]  bitcnt;
      logic [31:0] rx;
      logic [7:0]  crc_rx;
      logic [7:0]  crc_tx;
      logic [15:0] rd;
      logic        sdo;
      logic        sdo_oe;
      logic [15:0] ctrl;
      logic [15:0] occfg;
      logic [15:0] crccfg;
      logic [9:0]  flags;
      logic [7:0]  oc_cnt;
      logic [31:0] wd_cnt;
      logic        fault_n;
      logic        gate_en;
      logic        cp_en;
      logic        sense_en;
   } dev_t;

   dev_t        s;
   dev_t        nxt_s;
   logic        tx_bit;
   logic [7:0]  crc_rx_step;
   logic [7:0]  crc_tx_step;

   ////////////////////////////////////////////////////////////////////////
   // Register read mux

   function automatic logic [15:0] reg_read(input dev_t st, input logic [6:0] addr);
      logic [15:0] val;
      val = 16'h0000;
      case (addr)
         gd_pkg::REG_FLAGS:  val = {6'h00, st.flags};
         gd_pkg::REG_CTRL:   val = st.ctrl;
         gd_pkg::REG_OCCFG:  val = st.occfg;
         gd_pkg::REG_CRCCFG: val = st.crccfg;
         default:            val = 16'h0000;
      endcase
      return val;
   endfunction : reg_read

   ////////////////////////////////////////////////////////////////////////
   // Outgoing bit and checksum steps

   always_comb begin
      if (s.bitcnt == 6'h00) begin
         tx_bit = ~s.fault_n;
      end else if (s.bitcnt <= gd_pkg::CMD_LAST) begin
         tx_bit = s.rx[0];
      end else if (s.bitcnt < gd_pkg::DATA_END) begin
         tx_bit = s.rd[15];
      end else begin
         tx_bit = s.crc_tx[7];
      end
   end

   crc8_step u_crc_rx (
      .i_crc (s.crc_rx),
      .i_bit (s.sdi_sy[1]),
      .o_crc (crc_rx_step)
   );

   crc8_step u_crc_tx (
      .i_crc (s.crc_tx),
      .i_bit (tx_bit),
      .o_crc (crc_tx_step)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic        cs_fall;
      logic        cs_rise;
      logic        sclk_rise;
      logic        sclk_fall;
      logic        crc_en;
      logic        valid;
      logic        clr;
      logic        wd_evt;
      logic        oc_evt;
      logic [7:0]  cmd;
      logic [15:0] data;
      logic [7:0]  oc_lim;
      logic [9:0]  cond;
      cs_fall   = 1'b0;
      cs_rise   = 1'b0;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      crc_en    = 1'b0;
      valid     = 1'b0;
      clr       = 1'b0;
      wd_evt    = 1'b0;
      oc_evt    = 1'b0;
      cmd       = 8'h00;
      data      = 16'h0000;
      oc_lim    = 8'h00;
      cond      = 10'h000;
      nxt_s     = s;

      nxt_s.cs_sy   = {s.cs_sy[1:0], link.cs_n};
      nxt_s.sclk_sy = {s.sclk_sy[1:0], link.sclk};
      nxt_s.sdi_sy  = {s.sdi_sy[0], link.sdi};
      nxt_s.pin_s1  = {i_phase_comparator, i_high_side_input, i_thermal_warning, i_overtemp_shutdown,
                       i_drain_source_overcurrent, i_gate_supply_undervoltage, i_supply_undervoltage};
      nxt_s.pin_s2  = s.pin_s1;

      cs_fall   = ~s.cs_sy[1] & s.cs_sy[2];
      cs_rise   = s.cs_sy[1] & ~s.cs_sy[2];
      sclk_rise = s.sclk_sy[1] & ~s.sclk_sy[2];
      sclk_fall = ~s.sclk_sy[1] & s.sclk_sy[2];
      // Checksum on unless disable value held
      crc_en    = (s.crccfg != gd_pkg::CRC_OFF_VAL);

      if (cs_fall) begin
         nxt_s.bitcnt = 6'h00;
         nxt_s.crc_rx = gd_pkg::CRC_INIT;
         nxt_s.crc_tx = gd_pkg::CRC_INIT;
         nxt_s.sdo    = ~s.fault_n;
         nxt_s.sdo_oe = 1'b1;
      end else if (cs_rise) begin
         nxt_s.sdo    = 1'b0;
         nxt_s.sdo_oe = 1'b0;
         cmd  = crc_en ? s.rx[31:24] : s.rx[23:16];
         data = crc_en ? s.rx[23:8] : s.rx[15:0];
         valid = crc_en ? (s.bitcnt == gd_pkg::LEN_CRC && s.crc_rx == 8'h00)
                        : (s.bitcnt == gd_pkg::LEN_NOCRC);
         if (valid && !cmd[0]) begin
            case (cmd[7:1])
               gd_pkg::REG_CTRL: begin
                  nxt_s.ctrl = data & ~(16'h0001 << gd_pkg::CTRL_CLR);
                  clr        = data[gd_pkg::CTRL_CLR];
               end
               gd_pkg::REG_OCCFG:  nxt_s.occfg  = data;
               gd_pkg::REG_CRCCFG: nxt_s.crccfg = data;
               default: ;
            endcase
         end
      end else if (!s.cs_sy[1]) begin
         // Capture on falling edge, MSB first
         if (sclk_fall) begin
            nxt_s.rx     = {s.rx[30:0], s.sdi_sy[1]};
            nxt_s.crc_rx = crc_rx_step;
            if (s.bitcnt != 6'h3f) begin
               nxt_s.bitcnt = s.bitcnt + 6'h01;
            end
            if (s.bitcnt == gd_pkg::CMD_LAST) begin
               nxt_s.rd = reg_read(s, s.rx[6:0]);
            end
         end
         if (sclk_rise) begin
            nxt_s.sdo = tx_bit;
            if (s.bitcnt < gd_pkg::DATA_END) begin
               nxt_s.crc_tx = crc_tx_step;
            end else begin
               nxt_s.crc_tx = {s.crc_tx[6:0], 1'b0};
            end
            if (s.bitcnt >= gd_pkg::DATA_FIRST && s.bitcnt < gd_pkg::DATA_END) begin
               nxt_s.rd = {s.rd[14:0], 1'b0};
            end
         end
      end

      if (!s.ctrl[gd_pkg::CTRL_WDT]) begin
         nxt_s.wd_cnt = 32'h0;
      end else if (valid) begin
         wd_evt       = (s.wd_cnt < WD_LOWER_CYC) || (s.wd_cnt > WD_UPPER_CYC);
         nxt_s.wd_cnt = 32'h0;
      end else if (s.wd_cnt <= WD_UPPER_CYC) begin
         wd_evt       = (s.wd_cnt == WD_UPPER_CYC);
         nxt_s.wd_cnt = s.wd_cnt + 32'h1;
      end

      oc_lim = 8'(s.occfg[3:0] * gd_pkg::OC_DG_STEP_CYC);
      if (!s.pin_s2[2]) begin
         nxt_s.oc_cnt = 8'h00;
      end else if (s.oc_cnt != 8'hff) begin
         nxt_s.oc_cnt = s.oc_cnt + 8'h01;
      end
      oc_evt = s.pin_s2[2] && (s.oc_cnt >= oc_lim);

      cond[gd_pkg::FLG_SUV]        = s.pin_s2[0];
      cond[gd_pkg::FLG_GUV]        = s.pin_s2[1];
      cond[gd_pkg::FLG_OC]         = oc_evt;
      cond[gd_pkg::FLG_OVERTEMP_SHUTDOWN]       = s.pin_s2[3] & s.ctrl[gd_pkg::CTRL_OVERTEMP_SHUTDOWN];
      cond[gd_pkg::FLG_WDT]        = wd_evt;
      cond[gd_pkg::FLG_SPI]        = cs_rise & ~valid;
      cond[gd_pkg::FLG_PHC +: 3]   = s.pin_s2[7:5] ^ s.pin_s2[10:8];
      cond[gd_pkg::FLG_OTW]        = s.pin_s2[4];
      // Set wins, clear drops only idle flags
      nxt_s.flags = cond | (s.flags & ~{gd_pkg::NFLAGS{clr}});

      // Pin mirrors OR of FAULT_MASK flags, plus FLG_OTW while CTRL_WARN is clear
      nxt_s.fault_n  = ~(|(nxt_s.flags & gd_pkg::FAULT_MASK)
                         | (nxt_s.flags[gd_pkg::FLG_OTW] & ~s.ctrl[gd_pkg::CTRL_WARN]));
      nxt_s.gate_en  = ~(nxt_s.flags[gd_pkg::FLG_SUV] | nxt_s.flags[gd_pkg::FLG_GUV]
                         | nxt_s.flags[gd_pkg::FLG_OC] | nxt_s.flags[gd_pkg::FLG_OVERTEMP_SHUTDOWN]);
      nxt_s.cp_en    = ~(nxt_s.flags[gd_pkg::FLG_SUV] | nxt_s.flags[gd_pkg::FLG_GUV]
                         | nxt_s.flags[gd_pkg::FLG_OVERTEMP_SHUTDOWN]);
      nxt_s.sense_en = ~nxt_s.flags[gd_pkg::FLG_OVERTEMP_SHUTDOWN];
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s          <= '0;
         s.cs_sy    <= 3'h7;
         s.crc_rx   <= gd_pkg::CRC_INIT;
         s.crc_tx   <= gd_pkg::CRC_INIT;
         s.ctrl     <= gd_pkg::CTRL_RESET;
         s.occfg    <= gd_pkg::OCCFG_RESET;
         s.crccfg   <= gd_pkg::CRCCFG_RESET;
         s.fault_n  <= 1'b1;
         s.gate_en  <= 1'b1;
         s.cp_en    <= 1'b1;
         s.sense_en <= 1'b1;
      end else begin
         s <= nxt_s;
      end
   end

   assign link.sdo             = s.sdo;
   assign link.sdo_oe          = s.sdo_oe;
   assign o_fault_n            = s.fault_n;
   assign o_gate_enable        = s.gate_en;
   assign o_charge_pump_enable = s.cp_en;
   assign o_sense_enable       = s.sense_en;
   assign o_oc_threshold       = s.occfg[7:4];
endmodule : spi_fault_device

// *** rtl/gd_pkg.sv ***
package gd_pkg;
   // Clock and timing
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          CS_GAP_NS      = 400;
   localparam int          CS_GAP_CYC     = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SCLK_HALF_CYC  = 8;
   localparam int          OC_DG_STEP_NS  = 100;
   localparam logic [7:0]  OC_DG_STEP_CYC = 8'((OC_DG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int          WD_LOWER_US    = 1000;
   localparam int          WD_UPPER_US    = 10000;
   localparam int          WD_LOWER_CYC   = (WD_LOWER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          WD_UPPER_CYC   = (WD_UPPER_US * 1000) / CLK_PERIOD_NS;
   // Frame layout
   localparam logic [7:0]  CRC_POLY       = 8'h2f;
   localparam logic [7:0]  CRC_INIT       = 8'hff;
   localparam logic [5:0]  LEN_CRC        = 6'h20;
   localparam logic [5:0]  LEN_NOCRC      = 6'h18;
   localparam logic [5:0]  CMD_LAST       = 6'h07;
   localparam logic [5:0]  DATA_FIRST     = 6'h08;
   localparam logic [5:0]  DATA_END       = 6'h18;
   // Device register map (7-bit addresses)
   localparam logic [6:0]  REG_FLAGS      = 7'h00;
   localparam logic [6:0]  REG_CTRL       = 7'h01;
   localparam logic [6:0]  REG_OCCFG      = 7'h02;
   localparam logic [6:0]  REG_CRCCFG     = 7'h1c;
   localparam logic [15:0] CRC_OFF_VAL    = 16'h0009;
   localparam logic [15:0] CTRL_RESET     = 16'h000c;
   localparam logic [15:0] OCCFG_RESET    = 16'h0000;
   localparam logic [15:0] CRCCFG_RESET   = 16'h0000;
   localparam int          CTRL_WDT       = 0;
   localparam int          CTRL_CLR       = 1;
   localparam int          CTRL_WARN      = 2;
   localparam int          CTRL_OVERTEMP_SHUTDOWN      = 3;
   // Flag bits
   localparam int          NFLAGS         = 10;
   localparam int          FLG_SUV        = 0;
   localparam int          FLG_GUV        = 1;
   localparam int          FLG_OC         = 2;
   localparam int          FLG_OVERTEMP_SHUTDOWN       = 3;
   localparam int          FLG_WDT        = 4;
   localparam int          FLG_SPI        = 5;
   localparam int          FLG_PHC        = 6;
   localparam int          FLG_OTW        = 9;
   localparam logic [9:0]  FAULT_MASK     = 10'h1df;
   // Host command port
   localparam logic [1:0]  HREG_DATA      = 2'h0;
   localparam logic [1:0]  HREG_CMD       = 2'h1;
   localparam logic [1:0]  HREG_STAT      = 2'h2;
   localparam logic [1:0]  HREG_RDATA     = 2'h3;
   localparam int          HCMD_CRC_BIT   = 8;

   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_LEAD = 6'h02,
      H_HIGH = 6'h04,
      H_LOW  = 6'h08,
      H_TAIL = 6'h10,
      H_GAP  = 6'h20
   } host_st_t;
endpackage : gd_pkg

// *** rtl/spi_link_if.sv ***
interface spi_link_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic sdo_line;

   // Released line reads low
   assign sdo_line = sdo_oe & sdo;

   modport device (input sclk, input cs_n, input sdi, output sdo, output sdo_oe);
   modport host   (output sclk, output cs_n, output sdi, input sdo_line);
endinterface : spi_link_if

// *** rtl/crc8_step.sv ***
module crc8_step (
   input  wire logic [7:0] i_crc,
   input  wire logic       i_bit,
   output logic      [7:0] o_crc
);
   logic fb;

   assign fb    = i_crc[7] ^ i_bit;
   assign o_crc = {i_crc[6:0], 1'b0} ^ (fb ? gd_pkg::CRC_POLY : 8'h00);
endmodule : crc8_step

// *** rtl/spi_fault_host.sv ***
module spi_fault_host #(
   parameter int unsigned SCLK_HALF = gd_pkg::SCLK_HALF_CYC
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_b,
   spi_link_if.host         link,
   input  wire logic [1:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata
);
   typedef struct packed {
      gd_pkg::host_st_t st;
      logic [7:0]       half;
      logic [7:0]       gap;
      logic [5:0]       bitcnt;
      logic [5:0]       len;
      logic [23:0]      tx;
      logic [7:0]       crc_tx;
      logic [7:0]       crc_rx;
      logic [31:0]      rx;
      logic [1:0]       sdo_sy;
      logic             sclk;
      logic             cs_n;
      logic             sdi;
      logic [15:0]      wdata;
      logic [7:0]       status;
      logic [15:0]      rdat;
      logic             crc_ok;
      logic [31:0]      rdata;
   } host_t;

   host_t      s;
   host_t      nxt_s;
   logic       tx_bit;
   logic [7:0] crc_tx_step;
   logic [7:0] crc_rx_step;

   assign tx_bit = (s.bitcnt < gd_pkg::DATA_END) ? s.tx[23] : s.crc_tx[7];

   crc8_step u_crc_tx (
      .i_crc (s.crc_tx),
      .i_bit (tx_bit),
      .o_crc (crc_tx_step)
   );

   crc8_step u_crc_rx (
      .i_crc (s.crc_rx),
      .i_bit (s.sdo_sy[1]),
      .o_crc (crc_rx_step)
   );

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer

   always_comb begin
      logic tick;
      tick          = (s.half == 8'(SCLK_HALF - 1));
      nxt_s         = s;
      nxt_s.sdo_sy  = {s.sdo_sy[0], link.sdo_line};
      nxt_s.half    = tick ? 8'h00 : s.half + 8'h01;
      nxt_s.rdata   = 32'h0;

      case (s.st)
         gd_pkg::H_IDLE: begin
            nxt_s.half = 8'h00;
            if (i_wr && i_addr == gd_pkg::HREG_CMD) begin
               nxt_s.len    = i_wdata[gd_pkg::HCMD_CRC_BIT] ? gd_pkg::LEN_CRC : gd_pkg::LEN_NOCRC;
               nxt_s.tx     = {i_wdata[7:0], s.wdata};
               nxt_s.crc_tx = gd_pkg::CRC_INIT;
               nxt_s.crc_rx = gd_pkg::CRC_INIT;
               nxt_s.bitcnt = 6'h00;
               nxt_s.cs_n   = 1'b0;
               nxt_s.sdi    = i_wdata[7];
               nxt_s.st     = gd_pkg::H_LEAD;
            end
         end
         gd_pkg::H_LEAD, gd_pkg::H_LOW: begin
            if (tick) begin
               // Launch MSB first on rising edge
               nxt_s.sclk = 1'b1;
               nxt_s.sdi  = tx_bit;
               if (s.bitcnt < gd_pkg::DATA_END) begin
                  nxt_s.tx     = {s.tx[22:0], 1'b0};
                  nxt_s.crc_tx = crc_tx_step;
               end else begin
                  nxt_s.crc_tx = {s.crc_tx[6:0], 1'b0};
               end
               nxt_s.st = gd_pkg::H_HIGH;
            end
         end
         gd_pkg::H_HIGH: begin
            if (tick) begin
               nxt_s.sclk   = 1'b0;
               nxt_s.rx     = {s.rx[30:0], s.sdo_sy[1]};
               nxt_s.crc_rx = crc_rx_step;
               nxt_s.bitcnt = s.bitcnt + 6'h01;
               nxt_s.st     = (s.bitcnt + 6'h01 == s.len) ? gd_pkg::H_TAIL : gd_pkg::H_LOW;
            end
         end
         gd_pkg::H_TAIL: begin
            if (tick) begin
               nxt_s.cs_n = 1'b1;
               nxt_s.sdi  = 1'b0;
               if (s.len == gd_pkg::LEN_CRC) begin
                  nxt_s.status = s.rx[31:24];
                  nxt_s.rdat   = s.rx[23:8];
                  nxt_s.crc_ok = (s.crc_rx == 8'h00);
               end else begin
                  nxt_s.status = s.rx[23:16];
                  nxt_s.rdat   = s.rx[15:0];
                  nxt_s.crc_ok = 1'b1;
               end
               nxt_s.gap = 8'h00;
               nxt_s.st  = gd_pkg::H_GAP;
            end
         end
         gd_pkg::H_GAP: begin
            nxt_s.gap = s.gap + 8'h01;
            if (s.gap == 8'(gd_pkg::CS_GAP_CYC - 1)) begin
               nxt_s.st = gd_pkg::H_IDLE;
            end
         end
         default: nxt_s.st = gd_pkg::H_IDLE;
      endcase

      if (i_wr && i_addr == gd_pkg::HREG_DATA) begin
         nxt_s.wdata = i_wdata[15:0];
      end
      if (i_rd) begin
         case (i_addr)
            gd_pkg::HREG_DATA:  nxt_s.rdata = {16'h0000, s.wdata};
            gd_pkg::HREG_STAT:  nxt_s.rdata = {16'h0000, s.status, 6'h00, s.crc_ok, s.st != gd_pkg::H_IDLE};
            gd_pkg::HREG_RDATA: nxt_s.rdata = {16'h0000, s.rdat};
            default:            nxt_s.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s        <= '0;
         s.st     <= gd_pkg::H_IDLE;
         s.cs_n   <= 1'b1;
         s.crc_tx <= gd_pkg::CRC_INIT;
         s.crc_rx <= gd_pkg::CRC_INIT;
         s.len    <= gd_pkg::LEN_CRC;
      end else begin
         s <= nxt_s;
      end
   end

   assign link.sclk = s.sclk;
   assign link.cs_n = s.cs_n;
   assign link.sdi  = s.sdi;
   assign o_rdata   = s.rdata;
endmodule : spi_fault_host

// *** tb/spi_link_monitor.sv ***
module spi_link_monitor (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_sdi,
   input wire logic i_sdo,
   input wire logic i_sdo_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] gap_ff;
   logic [5:0] bits_ff;
   logic       sclk_ff;
   logic       sclk;
   logic       cs_n;
   logic       sdi;
   logic       sdo;
   logic       sdo_oe;

   assign sclk   = i_sclk;
   assign cs_n   = i_cs_n;
   assign sdi    = i_sdi;
   assign sdo    = i_sdo;
   assign sdo_oe = i_sdo_oe;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);

   // Deselect time and clock falls per frame
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gap_ff  <= 6'h28;
         bits_ff <= 6'h00;
         sclk_ff <= 1'b0;
      end else begin
         sclk_ff <= sclk;
         gap_ff  <= !cs_n ? 6'h00 : (gap_ff == 6'h28 ? gap_ff : gap_ff + 6'h01);
         bits_ff <= cs_n ? 6'h00 : bits_ff + {5'h00, sclk_ff & !sclk};
      end
   end
   ////////////////////////////////////////
   sequence s_lead;
      !sclk [*8] ##1 sclk;
   endsequence
   sequence s_high;
      sclk [*8] ##1 !sclk;
   endsequence

   property p_clk_low_select;   $fell(cs_n) |-> s_lead; endproperty
   property p_clk_low_release;  $rose(cs_n) |-> !sclk; endproperty
   property p_high_phase;       $rose(sclk) |-> s_high; endproperty
   property p_cs_gap;           $fell(cs_n) |-> gap_ff >= 6'h28; endproperty
   property p_bit_count;
      $rose(cs_n) |-> bits_ff == gd_pkg::LEN_CRC || bits_ff == gd_pkg::LEN_NOCRC;
   endproperty
   property p_sdi_launch;       !cs_n && !$past(cs_n) && $changed(sdi) |-> $rose(sclk); endproperty
   property p_sdo_hold;         $fell(sclk) && !cs_n |-> $stable(sdo) [*8]; endproperty
   property p_sdo_release;      cs_n [*8] |-> !sdo_oe; endproperty
   property p_sdo_drive;        !cs_n [*6] |-> sdo_oe; endproperty

   a_clk_low_select:  assert property (p_clk_low_select) else $error("clock not low at select");
   a_clk_low_release: assert property (p_clk_low_release) else $error("clock not low at release");
   a_high_phase:      assert property (p_high_phase) else $error("clock high phase wrong");
   a_cs_gap:          assert property (p_cs_gap) else $error("deselect gap too short");
   a_bit_count:       assert property (p_bit_count) else $error("frame length wrong");
   a_sdi_launch:      assert property (p_sdi_launch) else $error("input data moved off rising edge");
   a_sdo_hold:        assert property (p_sdo_hold) else $error("output data moved near falling edge");
   a_sdo_release:     assert property (p_sdo_release) else $error("output driven while deselected");
   a_sdo_drive:       assert property (p_sdo_drive) else $error("output not driven in frame");
endmodule : spi_link_monitor

// *** tb/tb_spi_slave_fault_supervisor.sv ***
module tb_spi_slave_fault_supervisor;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk_sys;
   logic        i_rst_b;
   logic [1:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic [4:0]  flt;
   logic [2:0]  hsi;
   logic [2:0]  cmp;
   logic        fault_n;
   logic        gate_en;
   logic        pump_en;
   logic        sense_en;
   logic [3:0]  oc_thr;
   int          fail_count;
   int          compares;

   spi_link_if spi_link_if_i ();
   spi_fault_host spi_fault_host_i (.i_clk_sys, .i_rst_b, .link(spi_link_if_i), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
   spi_fault_device #(.WD_LOWER_CYC(1500), .WD_UPPER_CYC(3000)) spi_fault_device_i (.i_clk_sys,
      .i_rst_b, .link(spi_link_if_i), .i_supply_undervoltage(flt[0]), .i_gate_supply_undervoltage(flt[1]),
      .i_drain_source_overcurrent(flt[2]), .i_overtemp_shutdown(flt[3]), .i_thermal_warning(flt[4]),
      .i_high_side_input(hsi), .i_phase_comparator(cmp), .o_fault_n(fault_n), .o_gate_enable(gate_en),
      .o_charge_pump_enable(pump_en), .o_sense_enable(sense_en), .o_oc_threshold(oc_thr));
   spi_link_monitor spi_link_monitor_i (.i_clk_sys, .i_rst_b, .i_sclk(spi_link_if_i.sclk),
      .i_cs_n(spi_link_if_i.cs_n), .i_sdi(spi_link_if_i.sdi), .i_sdo(spi_link_if_i.sdo),
      .i_sdo_oe(spi_link_if_i.sdo_oe));

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   ////////////////////////////////////////
   task automatic results;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   task automatic ck(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : ck

   task automatic hw(input logic [1:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge i_clk_sys);
      wr    <= 1'b0;
   endtask : hw

   task automatic hr(input logic [1:0] a, output logic [31:0] d);
      @(posedge i_clk_sys);
      addr <= a;
      rd   <= 1'b1;
      @(posedge i_clk_sys);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : hr

   // One frame, then status, checksum result and reply data
   task automatic fr(input logic [7:0] cmd, input logic [15:0] d, input logic crc, input logic [7:0] est,
                     input logic [15:0] ed);
      logic [31:0] s;
      hw(gd_pkg::HREG_DATA, {16'h0000, d});
      hw(gd_pkg::HREG_CMD, {23'h000000, crc, cmd});
      s = 32'h00000001;
      for (int n = 0; n < 2000 && s[0] !== 1'b0; n++) hr(gd_pkg::HREG_STAT, s);
      ck(s[15:0], {est, 8'h02});
      hr(gd_pkg::HREG_RDATA, s);
      ck(s[15:0], ed);
   endtask : fr
   ////////////////////////////////////////
   task automatic t_reset_read;
      fr(8'h03, 16'h0000, 1'b1, 8'h01, gd_pkg::CTRL_RESET);
   endtask : t_reset_read

   task automatic t_nocrc;
      fr(8'h38, gd_pkg::CRC_OFF_VAL, 1'b1, 8'h1c, 16'h0000);
      fr(8'h03, 16'h0000, 1'b0, 8'h01, gd_pkg::CTRL_RESET);
      fr(8'h38, 16'h0000, 1'b0, 8'h1c, gd_pkg::CRC_OFF_VAL);
      // Short frame with checksum on: discarded, error flagged
      fr(8'h02, 16'h000d, 1'b0, 8'h01, gd_pkg::CTRL_RESET);
      fr(8'h01, 16'h0000, 1'b1, 8'h00, 16'h0020);
   endtask : t_nocrc

   task automatic t_faults;
      @(posedge i_clk_sys);
      flt <= 5'h05;
      hsi <= 3'h7;
      repeat (30) @(posedge i_clk_sys);
      flt <= 5'h04;
      hsi <= 3'h0;
      repeat (10) @(posedge i_clk_sys);
      ck({13'h0000, fault_n, gate_en, pump_en}, 16'h0000);
      fr(8'h01, 16'h0000, 1'b1, 8'h80, 16'h01e5);
      fr(8'h02, 16'h000e, 1'b1, 8'h81, gd_pkg::CTRL_RESET);
      fr(8'h01, 16'h0000, 1'b1, 8'h80, 16'h0004);
      @(posedge i_clk_sys);
      flt <= 5'h00;
      fr(8'h02, 16'h000e, 1'b1, 8'h81, gd_pkg::CTRL_RESET);
      fr(8'h01, 16'h0000, 1'b1, 8'h00, 16'h0000);
      ck({13'h0000, fault_n, gate_en, pump_en}, 16'h0007);
   endtask : t_faults

   task automatic t_wdog;
      fr(8'h02, 16'h000d, 1'b1, 8'h01, gd_pkg::CTRL_RESET);
      // In-window access, then an early one
      repeat (1500) @(posedge i_clk_sys);
      fr(8'h03, 16'h0000, 1'b1, 8'h01, 16'h000d);
      fr(8'h02, 16'h000c, 1'b1, 8'h01, 16'h000d);
      fr(8'h01, 16'h0000, 1'b1, 8'h80, 16'h0010);
      fr(8'h02, 16'h000e, 1'b1, 8'h81, 16'h000c);
      fr(8'h01, 16'h0000, 1'b1, 8'h00, 16'h0000);
      // No access past the upper limit
      fr(8'h02, 16'h000d, 1'b1, 8'h01, 16'h000c);
      repeat (3100) @(posedge i_clk_sys);
      fr(8'h01, 16'h0000, 1'b1, 8'h80, 16'h0010);
      fr(8'h02, 16'h000e, 1'b1, 8'h81, 16'h000d);
      fr(8'h01, 16'h0000, 1'b1, 8'h80, 16'h0010);
      fr(8'h02, 16'h000e, 1'b1, 8'h81, 16'h000c);
      fr(8'h01, 16'h0000, 1'b1, 8'h00, 16'h0000);
   endtask : t_wdog

   task automatic t_temp;
      @(posedge i_clk_sys);
      flt <= 5'h10;
      repeat (10) @(posedge i_clk_sys);
      ck({12'h000, fault_n, gate_en, pump_en, sense_en}, 16'h000f);
      flt <= 5'h18;
      repeat (10) @(posedge i_clk_sys);
      ck({12'h000, fault_n, gate_en, pump_en, sense_en}, 16'h0000);
      fr(8'h01, 16'h0000, 1'b1, 8'h80, 16'h0208);
      @(posedge i_clk_sys);
      flt <= 5'h00;
      fr(8'h02, 16'h000e, 1'b1, 8'h81, gd_pkg::CTRL_RESET);
      fr(8'h01, 16'h0000, 1'b1, 8'h00, 16'h0000);
      ck({12'h000, fault_n, gate_en, pump_en, sense_en}, 16'h000f);
   endtask : t_temp

   task automatic t_ocdg;
      fr(8'h04, 16'h0035, 1'b1, 8'h02, gd_pkg::OCCFG_RESET);
      ck({12'h000, oc_thr}, 16'h0003);
      // Pulse shorter than the 50-cycle deglitch
      @(posedge i_clk_sys);
      flt <= 5'h04;
      repeat (30) @(posedge i_clk_sys);
      flt <= 5'h00;
      repeat (10) @(posedge i_clk_sys);
      ck({13'h0000, fault_n, gate_en, pump_en}, 16'h0007);
      flt <= 5'h04;
      repeat (80) @(posedge i_clk_sys);
      flt <= 5'h00;
      ck({13'h0000, fault_n, gate_en, pump_en}, 16'h0001);
      fr(8'h02, 16'h000e, 1'b1, 8'h81, gd_pkg::CTRL_RESET);
      fr(8'h01, 16'h0000, 1'b1, 8'h00, 16'h0000);
   endtask : t_ocdg

   initial begin
      i_rst_b = 1'b0;
      addr = 2'h0;
      wdata = 32'h00000000;
      wr = 1'b0;
      rd = 1'b0;
      flt = 5'h00;
      hsi = 3'h0;
      cmp = 3'h0;
      fail_count = 0;
      compares = 0;
      repeat (6) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      t_reset_read;
      t_nocrc;
      t_faults;
      t_temp;
      t_ocdg;
      t_wdog;
      results;
   end

   initial begin
      repeat (60000) @(posedge i_clk_sys);
      fail_count++;
      results;
   end
endmodule : tb_spi_slave_fault_supervisor
